// ### common/pcsd_pkg.sv
// Constants, types and message codes for the pump command and status decoder.
// Assumes a single 125 MHz clock domain and an Avalon-MM register master.
package pcsd_pkg;
	// Register byte offsets
	localparam logic [5:0] PCSD_OFF_CMD = 6'h00;
	localparam logic [5:0] PCSD_OFF_PARAM = 6'h04;
	localparam logic [5:0] PCSD_OFF_CTRL = 6'h08;
	localparam logic [5:0] PCSD_OFF_STATUS = 6'h0c;
	localparam logic [5:0] PCSD_OFF_RESP = 6'h10;
	localparam logic [5:0] PCSD_OFF_CI = 6'h14;
	localparam logic [5:0] PCSD_OFF_EVENT = 6'h18;
	localparam logic [5:0] PCSD_OFF_REMOTE = 6'h1c;
	// Command codes
	localparam logic [15:0] PCSD_CMD_CLAMP = 16'h01f0;
	localparam logic [15:0] PCSD_CMD_SXBITS = 16'h01f1;
	localparam logic [15:0] PCSD_CMD_EBITS = 16'h01f2;
	localparam logic [15:0] PCSD_CMD_SYNCDLY = 16'h01f3;
	localparam logic [15:0] PCSD_CMD_BUFEMPTY = 16'h01f4;
	localparam logic [15:0] PCSD_CMD_REMOTE = 16'h01f5;
	localparam logic [15:0] PCSD_CMD_DIAL = 16'h005a;
	localparam logic [3:0] PCSD_CI_SET_M = 4'h8;
	localparam logic [3:0] PCSD_CI_SET_N = 4'h9;
	localparam logic [7:0] PCSD_CI_REQ = 8'ha0;
	localparam logic [3:0] PCSD_CI_IDLE = 4'hf;
	localparam logic [2:0] PCSD_ARB_LOWEST = 3'h7;
	// Clamp encodings
	localparam logic [1:0] PCSD_CLAMP_USER = 2'h0;
	localparam logic [1:0] PCSD_CLAMP_ZERO = 2'h1;
	localparam logic [1:0] PCSD_CLAMP_ONE = 2'h3;
	// Tone digit range
	localparam logic [7:0] PCSD_DIGIT_MIN = 8'h10;
	localparam logic [7:0] PCSD_DIGIT_MAX = 8'h1f;
	// Reset value, fixed status codes and rate code
	localparam logic [7:0] PCSD_RST_SYNC = 8'h01;
	localparam logic [15:0] PCSD_IIS_FAX = 16'h006e;
	localparam logic [7:0] PCSD_FAX_PCOUNT = 8'h02;
	localparam logic [7:0] PCSD_RATE_600 = 8'h03;
	// Path modes
	typedef enum logic [2:0] {
		PCSD_PATH_OFF = 3'b000,
		PCSD_PATH_FAX = 3'b001,
		PCSD_PATH_DATA = 3'b010,
		PCSD_PATH_HALF = 3'b011,
		PCSD_PATH_RATE = 3'b100,
		PCSD_PATH_TONE = 3'b101,
		PCSD_PATH_BYPASS = 3'b111
	} pcsd_path_e;
	// Transmit frame control bits
	typedef struct packed {
		logic [1:0] clamp_select;
		logic [3:0] sx_bits;
		logic [6:0] e_bits;
	} pcsd_tx_ctrl_s;
	// Command sequencer states
	typedef enum logic [1:0] {
		PCSD_ST_IDLE = 2'b00,
		PCSD_ST_EXEC = 2'b01,
		PCSD_ST_DONE = 2'b10
	} pcsd_state_e;
endpackage : pcsd_pkg

// ### core/pcsd_top.sv
// Pump command decoder, C/I channel handler and status reporter.
// Assumes the link-side inputs come asynchronously from the serial bus side.
`timescale 1ns/100ps
`default_nettype none
module pcsd_top
	import pcsd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic [5:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic tx_empty_in,
	input wire logic frame_ok_in,
	input wire logic frame_bad_in,
	input wire logic [4:0] remote_status_in,
	input wire logic [3:0] ci_rx_in,
	input wire logic bus_access_bit_in,
	input wire logic [2:0] arbitration_address_in,
	input wire logic own_access_in,
	input wire logic access_request_in,
	input wire logic [7:0] rate_index_low_in,
	input wire logic [7:0] rate_index_high_in,
	input wire logic [1:0] orig_answer_mode_in,
	output logic [12:0] tx_ctrl_out,
	output logic mbox_discard_out,
	output logic rx_sync_out,
	output logic tone_start_out,
	output logic [3:0] tone_digit_code_out,
	output logic [3:0] ci_tx_out,
	output logic event_out
);
	// ====================================================================
	// Input synchronisers
	// ====================================================================
	localparam int SW = 1 + 1 + 1 + 5 + 4 + 1 + 3 + 1 + 1;
	logic [SW-1:0] sync1_ff; // First stage, read only by second
	logic [SW-1:0] sync2_ff; // Second stage
	// Two stage capture of link inputs
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {tx_empty_in, frame_ok_in, frame_bad_in, remote_status_in,
				ci_rx_in, bus_access_bit_in, arbitration_address_in, own_access_in,
				access_request_in};
			sync2_ff <= sync1_ff;
		end
	end
	wire s_empty = sync2_ff[SW-1];
	wire s_ok = sync2_ff[SW-2];
	wire s_bad = sync2_ff[SW-3];
	wire [4:0] s_remote = sync2_ff[SW-4 -: 5];
	wire [3:0] s_ci = sync2_ff[9:6];
	wire s_bac = sync2_ff[5];
	wire [2:0] s_addr = sync2_ff[4:2];
	wire s_own = sync2_ff[1];
	wire s_req = sync2_ff[0];

	// ====================================================================
	// Register bus decode
	// ====================================================================
	logic [31:0] cmd_ff; // Command word: code, parameter
	logic ci_arb_en_ff; // Arbitration channel enabled
	logic ci_channel_enable_ff; // C/I channel enabled
	logic [7:0] rate_ff; // Current rate selector for E7
	logic [2:0] pump_path_mode_ff; // Configured path mode
	logic ack_ff; // One-cycle answer to a request
	// Wait one cycle, then answer
	wire req = avs_read_in | avs_write_in;
	wire wr_go = avs_write_in & ack_ff;
	wire wr_cmd = wr_go & (avs_address_in == PCSD_OFF_CMD);
	wire wr_ctrl = wr_go & (avs_address_in == PCSD_OFF_CTRL);
	wire rd_event = avs_read_in & ack_ff & (avs_address_in == PCSD_OFF_EVENT);
	wire [15:0] code = cmd_ff[31:16];
	wire [7:0] parm = cmd_ff[7:0];
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			ack_ff <= 1'b0;
			avs_waitrequest_out <= 1'b1;
		end else begin
			ack_ff <= req & ~ack_ff;
			// Registered copy of the inverted answer strobe
			avs_waitrequest_out <= ~(req & ~ack_ff);
		end
	end

	// ====================================================================
	// Command sequencer
	// ====================================================================
	pcsd_state_e state_ff; // Sequencer state
	pcsd_state_e nxt_state;
	// Taken on write to the command register; executes next cycle
	always_comb begin
		case (state_ff)
			PCSD_ST_IDLE: nxt_state = wr_cmd ? PCSD_ST_EXEC : PCSD_ST_IDLE;
			PCSD_ST_EXEC: nxt_state = PCSD_ST_DONE;
			PCSD_ST_DONE: nxt_state = PCSD_ST_IDLE;
			default: nxt_state = PCSD_ST_IDLE;
		endcase
	end
	wire exec = (state_ff == PCSD_ST_EXEC);
	wire [7:0] ci_cmd = code[15:8];
	wire is_rate_path = (pump_path_mode_ff == PCSD_PATH_RATE);

	// Command register capture, also bus config
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= PCSD_ST_IDLE;
			cmd_ff <= '0;
			ci_arb_en_ff <= 1'b0;
			ci_channel_enable_ff <= 1'b0;
			rate_ff <= '0;
			pump_path_mode_ff <= PCSD_PATH_OFF;
		end else begin
			state_ff <= nxt_state;
			if (wr_cmd && state_ff == PCSD_ST_IDLE)
				cmd_ff <= avs_writedata_in;
			if (wr_ctrl) begin
				ci_channel_enable_ff <= avs_writedata_in[0];
				ci_arb_en_ff <= avs_writedata_in[1];
				pump_path_mode_ff <= avs_writedata_in[10:8];
				rate_ff <= avs_writedata_in[23:16];
			end
		end
	end

	// ====================================================================
	// Rate adaptation transmit control
	// ====================================================================
	pcsd_tx_ctrl_s tx_ff; // Frame control bits
	logic [4:0] remote_en_ff; // Remote status enables
	logic empty_arm_ff; // Buffer-empty indication armed
	logic [7:0] sync_frame_count_ff; // Frames needed for sync
	logic [7:0] good_cnt_ff; // Good frames seen
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_ff <= '0;
			remote_en_ff <= '0;
			sync_frame_count_ff <= PCSD_RST_SYNC;
			tone_start_out <= 1'b0;
			tone_digit_code_out <= '0;
		end else begin
			tone_start_out <= 1'b0;
			if (exec) begin
				case (code)
					PCSD_CMD_CLAMP: begin
						tx_ff.clamp_select <= parm[1:0];
					end
					PCSD_CMD_SXBITS: begin
						tx_ff.sx_bits <= parm[3:0];
					end
					PCSD_CMD_EBITS: begin
						tx_ff.e_bits <= parm[6:0];
					end
					PCSD_CMD_SYNCDLY: begin
						// Zero is outside the range; keep the current count
						if (parm != 8'h00)
							sync_frame_count_ff <= parm;
					end
					PCSD_CMD_REMOTE: begin
						remote_en_ff <= parm[4:0];
					end
					PCSD_CMD_DIAL: begin
						// Digit codes outside 10h..1Fh are ignored
						if (parm >= PCSD_DIGIT_MIN && parm <= PCSD_DIGIT_MAX) begin
							tone_start_out <= 1'b1;
							tone_digit_code_out <= parm[3:0];
						end
					end
					default: begin
						tone_start_out <= 1'b0;
					end
				endcase
			end
		end
	end
	// E7 replaced by pump bit at 600 bit/s in the rate path mode
	wire e7_pump = is_rate_path && (rate_ff == PCSD_RATE_600);
	logic e7_toggle_ff; // Multiframe alignment bit
	wire [12:0] tx_word = {tx_ff.clamp_select, tx_ff.sx_bits, tx_ff.e_bits[6:1],
		e7_pump ? e7_toggle_ff : tx_ff.e_bits[0]};
	// Mailbox data dropped under zero or one clamp
	wire discard = (tx_ff.clamp_select == PCSD_CLAMP_ZERO) ||
		(tx_ff.clamp_select == PCSD_CLAMP_ONE);
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			tx_ctrl_out <= '0;
			mbox_discard_out <= 1'b0;
			e7_toggle_ff <= 1'b0;
		end else begin
			tx_ctrl_out <= tx_word;
			mbox_discard_out <= discard;
			if (s_ok)
				e7_toggle_ff <= ~e7_toggle_ff;
		end
	end

	// ====================================================================
	// Receive synchronisation
	// ====================================================================
	wire sync_hit = s_ok && (good_cnt_ff + 8'h01 >= sync_frame_count_ff);
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			good_cnt_ff <= '0;
			rx_sync_out <= 1'b0;
		end else if (s_bad) begin
			good_cnt_ff <= '0;
			rx_sync_out <= 1'b0;
		end else if (s_ok && !rx_sync_out) begin
			good_cnt_ff <= good_cnt_ff + 8'h01;
			if (sync_hit)
				rx_sync_out <= 1'b1;
		end
	end

	// ====================================================================
	// Status events (sticky, cleared by reading)
	// ====================================================================
	logic [4:0] remote_prev_ff; // Last remote status
	logic empty_flag_ff; // Buffer-empty event pending
	logic [4:0] remote_flag_ff; // Remote change events pending
	logic empty_prev_ff; // Last buffer-empty level
	wire arm_cmd = exec && (code == PCSD_CMD_BUFEMPTY) && parm[0];
	wire empty_rise = s_empty & ~empty_prev_ff;
	wire empty_hit = empty_arm_ff & empty_rise;
	wire [4:0] remote_hit = (s_remote ^ remote_prev_ff) & remote_en_ff;
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			empty_arm_ff <= 1'b0;
			empty_prev_ff <= 1'b0;
			empty_flag_ff <= 1'b0;
			remote_prev_ff <= '0;
			remote_flag_ff <= '0;
			event_out <= 1'b0;
		end else begin
			empty_prev_ff <= s_empty;
			remote_prev_ff <= s_remote;
			// Fires once, then disarms until re-enabled
			if (arm_cmd)
				empty_arm_ff <= 1'b1;
			else if (empty_hit)
				empty_arm_ff <= 1'b0;
			// Set wins over read clear
			empty_flag_ff <= empty_hit | (empty_flag_ff & ~rd_event);
			remote_flag_ff <= remote_hit | (remote_flag_ff & {5{~rd_event}});
			event_out <= empty_hit | (|remote_hit) | empty_flag_ff | (|remote_flag_ff);
		end
	end

	// ====================================================================
	// C/I channel
	// ====================================================================
	logic [3:0] code_m_ff; // Code without bus access
	logic [3:0] code_n_ff; // Code with bus access
	logic [3:0] ci_last_ff; // Previous received sample
	logic [3:0] ci_valid_ff; // Accepted C/I code
	logic [3:0] ci_queue_ff; // Code reported to host
	logic ci_new_ff; // Unread report pending
	wire ci_stable = (s_ci == ci_last_ff);
	wire ci_change = ci_stable && (s_ci != ci_valid_ff);
	wire ci_req = exec && (ci_cmd == PCSD_CI_REQ);
	wire ci_set_m = exec && (ci_cmd[7:4] == PCSD_CI_SET_M);
	wire ci_set_n = exec && (ci_cmd[7:4] == PCSD_CI_SET_N);
	wire arb_free = ~s_req && s_bac && (s_addr == PCSD_ARB_LOWEST);
	logic [3:0] ci_sel;
	// Transmit code selection
	always_comb begin
		if (!ci_channel_enable_ff)
			ci_sel = PCSD_CI_IDLE;
		else if (!ci_arb_en_ff)
			ci_sel = code_m_ff;
		else if (s_own)
			ci_sel = code_n_ff;
		else if (arb_free)
			ci_sel = code_m_ff;
		else
			ci_sel = PCSD_CI_IDLE;
	end
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in) begin
			code_m_ff <= PCSD_CI_IDLE;
			code_n_ff <= PCSD_CI_IDLE;
			ci_last_ff <= PCSD_CI_IDLE;
			ci_valid_ff <= PCSD_CI_IDLE;
			ci_queue_ff <= PCSD_CI_IDLE;
			ci_new_ff <= 1'b0;
			ci_tx_out <= PCSD_CI_IDLE;
		end else begin
			ci_last_ff <= s_ci;
			ci_tx_out <= ci_sel;
			if (ci_set_m)
				code_m_ff <= ci_cmd[3:0];
			if (ci_set_n)
				code_n_ff <= ci_cmd[3:0];
			if (ci_stable)
				ci_valid_ff <= s_ci;
			// Change or explicit request reports; a change wins when both come in one cycle
			if (ci_change || ci_req) begin
				ci_queue_ff <= ci_change ? s_ci : ci_valid_ff;
				ci_new_ff <= 1'b1;
			end else if (rd_event) begin
				ci_new_ff <= 1'b0;
			end
		end
	end

	// ====================================================================
	// Status response and read mux
	// ====================================================================
	// Control word: mode 15:14, path 10:8, count 7:0
	wire [15:0] resp_ctrl = {orig_answer_mode_in, 3'b000, pump_path_mode_ff,
		PCSD_FAX_PCOUNT};
	// Rate index bytes reported as carried by the pump
	wire [31:0] resp_word = {resp_ctrl, rate_index_high_in, rate_index_low_in};
	logic [31:0] rd_mux;
	always_comb begin
		case (avs_address_in)
			PCSD_OFF_CMD: rd_mux = cmd_ff;
			PCSD_OFF_CTRL: rd_mux = {8'h00, rate_ff, 5'h00, pump_path_mode_ff,
				6'h00, ci_arb_en_ff, ci_channel_enable_ff};
			PCSD_OFF_STATUS: rd_mux = {16'h0000, PCSD_IIS_FAX};
			PCSD_OFF_RESP: rd_mux = resp_word;
			PCSD_OFF_CI: rd_mux = {19'h00000, ci_new_ff, ci_tx_out, ci_valid_ff,
				ci_queue_ff};
			PCSD_OFF_EVENT: rd_mux = {24'h000000, rx_sync_out, remote_flag_ff,
				empty_arm_ff, empty_flag_ff};
			PCSD_OFF_REMOTE: rd_mux = {11'h000, remote_en_ff, s_remote,
				sync_frame_count_ff, tx_word[12:11], 1'b0};
			default: rd_mux = 32'h00000000;
		endcase
	end
	always_ff @(posedge mclk_in or posedge reset_in) begin
		if (reset_in)
			avs_readdata_out <= '0;
		else
			avs_readdata_out <= (avs_read_in && !ack_ff) ? rd_mux : avs_readdata_out;
	end
endmodule : pcsd_top
`default_nettype wire

// ### tb/pcsd_monitor.sv
// Checker of the decoder's port timing and its output relations.
// Assumes binding onto pcsd_top and a single clock domain.
`timescale 1ns/100ps
`default_nettype none
module pcsd_monitor (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic frame_ok_in,
	input wire logic frame_bad_in,
	input wire logic [12:0] tx_ctrl_out,
	input wire logic mbox_discard_out,
	input wire logic rx_sync_out,
	input wire logic tone_start_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// ==========================================
	// Bus handshake
	a_wait_one_cycle: assert property ($fell(avs_waitrequest_out) |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	a_ack_needs_req: assert property (!avs_waitrequest_out |-> (avs_read_in || avs_write_in))
		else $error("answer without request");
	a_req_answered: assert property ((avs_read_in || avs_write_in) |-> ##[0:2] !avs_waitrequest_out)
		else $error("request not answered");
	a_read_data_held: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
		else $error("read data moved without read");
	// ==========================================
	// Transmit and receive controls
	a_clamp_discard: assert property (mbox_discard_out ==
		(tx_ctrl_out[12:11] == 2'h1 || tx_ctrl_out[12:11] == 2'h3))
		else $error("discard disagrees with clamp");
	a_tone_pulse: assert property (tone_start_out |=> !tone_start_out)
		else $error("tone start longer than a cycle");
	a_tone_cause: assert property ($rose(tone_start_out) |-> $past(avs_write_in, 2))
		else $error("tone without command write");
	a_sync_drop: assert property (frame_bad_in && !frame_ok_in |-> ##[1:5] !rx_sync_out)
		else $error("bad frame kept sync");
	c_tone: cover property (tone_start_out);
	c_discard: cover property ($rose(mbox_discard_out));
	c_sync: cover property ($rose(rx_sync_out));
endmodule : pcsd_monitor
bind pcsd_top pcsd_monitor u_pcsd_monitor (.mclk_in(mclk_in), .reset_in(reset_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.frame_ok_in(frame_ok_in), .frame_bad_in(frame_bad_in), .tx_ctrl_out(tx_ctrl_out),
	.mbox_discard_out(mbox_discard_out), .rx_sync_out(rx_sync_out),
	.tone_start_out(tone_start_out));
`default_nettype wire

// ### tb/pcsd_link_model.sv
// Link-side partner: received C/I value and frame check pulses.
// Assumes the bench raises a frame request for one clock per frame.
`timescale 1ns/100ps
`default_nettype none
module pcsd_link_model (
	input wire logic mclk_in,
	input wire logic [3:0] ci_code_in,
	input wire logic ok_req_in,
	input wire logic bad_req_in,
	output logic [3:0] ci_rx_out,
	output logic frame_ok_out,
	output logic frame_bad_out
);
	// One frame verdict per request, C/I value repeated every slot
	always_ff @(posedge mclk_in) begin
		ci_rx_out <= ci_code_in;
		frame_ok_out <= ok_req_in;
		frame_bad_out <= bad_req_in;
	end
endmodule : pcsd_link_model
`default_nettype wire

// ### tb/pump_command_status_decoder_test.sv
// Scenario bench for the pump command and status decoder.
// Assumes the package, pcsd_top and the link model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pump_command_status_decoder_test import pcsd_pkg::*;;
	logic mclk_in = 1'b0, reset_in = 1'b1, rd = 1'b0, wr = 1'b0, tx_empty = 1'b0;
	logic ok_req = 1'b0, bad_req = 1'b0, bac = 1'b1, own = 1'b0, areq = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rdat, rq;
	logic [4:0] remote = 5'h00;
	logic [3:0] ci_code = 4'h3, ci_rx, digit, ci_tx;
	logic [2:0] arb = 3'h7;
	logic [7:0] rate_index_low = 8'h08, rate_index_high = 8'h28;
	logic [1:0] orig_answer_mode = 2'h1;
	logic wq, fok, fbad, disc, sync, tone, ev;
	logic [12:0] txc;
	int err_count = 0, samples_checked = 0;
	always #4 mclk_in = ~mclk_in;
	pcsd_link_model u_pcsd_link_model (.mclk_in(mclk_in), .ci_code_in(ci_code),
		.ok_req_in(ok_req), .bad_req_in(bad_req), .ci_rx_out(ci_rx),
		.frame_ok_out(fok), .frame_bad_out(fbad));
	pcsd_top u_pcsd_top (.mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
		.tx_empty_in(tx_empty), .frame_ok_in(fok), .frame_bad_in(fbad),
		.remote_status_in(remote), .ci_rx_in(ci_rx), .bus_access_bit_in(bac),
		.arbitration_address_in(arb), .own_access_in(own), .access_request_in(areq),
		.rate_index_low_in(rate_index_low), .rate_index_high_in(rate_index_high), .orig_answer_mode_in(orig_answer_mode),
		.tx_ctrl_out(txc), .mbox_discard_out(disc), .rx_sync_out(sync),
		.tone_start_out(tone), .tone_digit_code_out(digit), .ci_tx_out(ci_tx),
		.event_out(ev));
	// ==========================================
	// Closing report
	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	// ==========================================
	// Bus cycle: hold until waitrequest seen low at an edge
	task automatic bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		// Request launched just after a rising edge
		@(posedge mclk_in);
		adr <= a;
		wdat <= d;
		rd <= !is_wr;
		wr <= is_wr;
		// Held until waitrequest is seen low at a rising edge
		for (int i = 0; i < 20 && !done; i++) begin
			@(posedge mclk_in);
			if (wq === 1'b0) begin
				done = 1'b1;
				rq = rdat;
				rd <= 1'b0;
				wr <= 1'b0;
			end
		end
		if (!done) begin
			$display("MISMATCH %0t bus timeout", $time);
			err_count++;
			give_verdict();
		end
	endtask : bus
	task automatic cmd(input logic [31:0] d);
		bus(1'b1, PCSD_OFF_CMD, d);
		repeat (4) @(posedge mclk_in);
	endtask : cmd
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rq, exp);
	endtask : rd_chk
	// ==========================================
	// Scenarios
	task automatic t_clamp;
		logic [1:0] cl [3] = '{PCSD_CLAMP_ZERO, PCSD_CLAMP_ONE, PCSD_CLAMP_USER};
		foreach (cl[i]) begin
			cmd({PCSD_CMD_CLAMP, 14'h0, cl[i]});
			chk(txc[12:11], cl[i]);
			chk(disc, cl[i] != 2'h0);
		end
	endtask : t_clamp
	task automatic t_frame_bits;
		logic s0, s1;
		cmd({PCSD_CMD_SXBITS, 8'h0, 8'h0a});
		chk(txc[10:7], 4'ha);
		cmd({PCSD_CMD_EBITS, 8'h0, 8'h55});
		chk(txc[6:0], 7'h55);
		bus(1'b1, PCSD_OFF_CTRL, 32'h0003_0400);
		cmd({PCSD_CMD_EBITS, 8'h0, 8'h7f});
		s0 = 1'b0;
		s1 = 1'b0;
		// Frame pulses drive the pump's own E7 alternation
		for (int i = 0; i < 64; i++) begin
			@(posedge mclk_in);
			ok_req <= (i % 8 == 0);
			s0 |= (txc[0] === 1'b0);
			s1 |= (txc[0] === 1'b1);
		end
		chk({s0, s1, txc[6:1]}, {2'b11, 6'h3f});
	endtask : t_frame_bits
	task automatic frame(input logic good, input logic exp);
		ok_req <= good;
		bad_req <= !good;
		@(posedge mclk_in);
		ok_req <= 1'b0;
		bad_req <= 1'b0;
		repeat (5) @(posedge mclk_in);
		chk(sync, exp);
	endtask : frame
	task automatic t_sync;
		cmd({PCSD_CMD_SYNCDLY, 8'h0, 8'h03});
		frame(1'b0, 1'b0);
		frame(1'b1, 1'b0);
		frame(1'b1, 1'b0);
		frame(1'b1, 1'b1);
	endtask : t_sync
	task automatic empty_edge(input logic exp);
		tx_empty <= 1'b0;
		repeat (4) @(posedge mclk_in);
		tx_empty <= 1'b1;
		repeat (6) @(posedge mclk_in);
		chk(ev, exp);
	endtask : empty_edge
	task automatic t_empty;
		cmd({PCSD_CMD_BUFEMPTY, 8'h0, 8'h01});
		empty_edge(1'b1);
		bus(1'b0, PCSD_OFF_EVENT, 32'h0);
		chk(rq[0], 1'b1);
		empty_edge(1'b0);
	endtask : t_empty
	// Only enabled remote status bits raise an event
	task automatic t_remote;
		cmd({PCSD_CMD_REMOTE, 8'h0, 8'h05});
		remote <= 5'h02;
		repeat (6) @(posedge mclk_in);
		chk(ev, 1'b0);
		remote <= 5'h06;
		repeat (6) @(posedge mclk_in);
		chk(ev, 1'b1);
		bus(1'b0, PCSD_OFF_EVENT, 32'h0);
		chk(rq[6:2], 5'h04);
	endtask : t_remote
	// Tone pulse stands one cycle, so every edge is watched
	task automatic t_dial;
		logic seen;
		logic [3:0] dg;
		for (int d = 16; d < 33; d++) begin
			bus(1'b1, PCSD_OFF_CMD, {(d == 32) ? 16'h005b : PCSD_CMD_DIAL, 8'h0, 8'(d)});
			chk(tone, 1'b0);
			seen = 1'b0;
			dg = 4'h0;
			for (int i = 0; i < 6; i++) begin
				@(posedge mclk_in);
				if (tone === 1'b1) begin
					seen = 1'b1;
					dg = digit;
				end
			end
			chk({seen, dg}, {d != 32, 4'(d)});
		end
	endtask : t_dial
	task automatic ci_chk(input logic [3:0] exp);
		repeat (6) @(posedge mclk_in);
		chk(ci_tx, exp);
	endtask : ci_chk
	task automatic t_ci;
		cmd(32'h9a00_0000);
		cmd(32'h8500_0000);
		bus(1'b1, PCSD_OFF_CTRL, 32'h0000_0001);
		ci_chk(4'h5);
		bus(1'b1, PCSD_OFF_CTRL, 32'h0000_0003);
		ci_chk(4'h5);
		bac <= 1'b0;
		arb <= 3'h2;
		ci_chk(PCSD_CI_IDLE);
		own <= 1'b1;
		ci_chk(4'ha);
		ci_code <= 4'hc;
		repeat (4) @(posedge mclk_in);
		cmd({PCSD_CI_REQ, 24'h0});
		bus(1'b0, PCSD_OFF_CI, 32'h0);
		chk(rq[3:0], 4'hc);
	endtask : t_ci
	task automatic t_status;
		bus(1'b1, PCSD_OFF_CTRL, {8'h00, 13'h0, PCSD_PATH_FAX, 8'h00});
		repeat (4) @(posedge mclk_in);
		rd_chk(PCSD_OFF_STATUS, 32'h0000_006e);
		rd_chk(PCSD_OFF_RESP, 32'h4102_2808);
		rd_chk(6'h3c, 32'h0);
	endtask : t_status
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge mclk_in);
		reset_in <= 1'b0;
		@(posedge mclk_in);
		chk(ci_tx, PCSD_CI_IDLE);
		t_clamp();
		t_frame_bits();
		t_sync();
		t_empty();
		t_remote();
		t_dial();
		t_ci();
		t_status();
		give_verdict();
	end
endmodule : pump_command_status_decoder_test
`default_nettype wire
